// file: core/flrm_params.svh
`ifndef FLRM_PARAMS_SVH
`define FLRM_PARAMS_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define FLRM_CLK_PERIOD_NS 10

// ----------------------------------------
// analog thresholds, for reference only
// ----------------------------------------
`define FLRM_OV_THRESH_MV 1850
`define FLRM_UV_MARGIN_MV 500
`define FLRM_MAIN_LOW_MARGIN_MV 10
`define FLRM_MAIN_HIGH_MARGIN_MV 40

// ----------------------------------------
// filter times and cycle counts (rounded up)
// ----------------------------------------
`define FLRM_OV_FILTER_NS 1000
`define FLRM_UV_FILTER_NS 3000
`define FLRM_UVLO_FILTER_NS 3000
`define FLRM_CYCLES(ns) (((ns) + `FLRM_CLK_PERIOD_NS - 1) / `FLRM_CLK_PERIOD_NS)
`define FLRM_OV_CYC `FLRM_CYCLES(`FLRM_OV_FILTER_NS)
`define FLRM_UV_CYC `FLRM_CYCLES(`FLRM_UV_FILTER_NS)
`define FLRM_UVLO_CYC `FLRM_CYCLES(`FLRM_UVLO_FILTER_NS)

// ----------------------------------------
// filter channel positions
// ----------------------------------------
`define FLRM_CH_OV 0
`define FLRM_CH_UV 1
`define FLRM_CH_UVLO 2
`define FLRM_NUM_CH 3
`define FLRM_FILT_W 16
`define FLRM_NUM_PINS 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define FLRM_GATE_RST 2'h0
`define FLRM_FAULT_RST 3'h0
`define FLRM_STBY_MAIN_RST 1'h1
`define FLRM_STBY_REG_RST 1'h0
`define FLRM_REG_EN_RST 1'h0

`endif

// file: core/flrm_pkg.sv
package flrm_pkg;

  // ----------------------------------------
  // comparator and control pins
  // ----------------------------------------
  typedef struct packed {
    logic ov_high;
    logic uv_low;
    logic supply_low;
    logic mux_ctrl;
    logic main_low;
    logic main_high;
  } flrm_cmp_t;

  // ----------------------------------------
  // switch commands
  // ----------------------------------------
  typedef struct packed {
    logic hs;
    logic ls;
  } flrm_gate_t;

  // ----------------------------------------
  // fault status
  // ----------------------------------------
  typedef struct packed {
    logic ov;
    logic uv;
    logic lockout;
  } flrm_fault_t;

  // ----------------------------------------
  // standby rail source
  // ----------------------------------------
  typedef enum logic {
    FLRM_SEL_MAIN,
    FLRM_SEL_REG
  } flrm_sel_state_t;

endpackage

// file: core/flrm_filter.sv
`timescale 1ns/1ns
`include "flrm_params.svh"

module flrm_filter #(
  parameter logic [`FLRM_FILT_W-1:0] CYCLES = 16'h0064
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // filtered level
  input wire logic in_level,
  output logic hit
);

  // ----------------------------------------
  // run counter, saturates at the limit
  // ----------------------------------------
  logic [`FLRM_FILT_W-1:0] cnt;
  wire at_limit = (cnt == CYCLES);
  wire [`FLRM_FILT_W-1:0] cnt_inc = cnt + 16'h0001;
  wire [`FLRM_FILT_W-1:0] next_cnt = !in_level ? 16'h0000 : (at_limit ? cnt : cnt_inc);
  wire next_hit = (next_cnt == CYCLES);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
      hit <= 1'h0;
    end else begin
      cnt <= next_cnt;
      hit <= next_hit;
    end
  end

endmodule // flrm_filter

// file: core/flrm_top.sv
`timescale 1ns/1ns
`include "flrm_params.svh"

// Overview of operation
// - after reset the over-voltage comparator on the sensed output voltage is watched all the time.
// - a confirmed over-voltage is latched and, outside lockout, drives low-side on and high-side off.
// - over-voltage must hold for 1 us before the latch sets.
// - an under-voltage of 500 mV below reference sets the under-voltage latch.
// - while the under-voltage latch is set and no over-voltage is latched both switch commands stay off.
// - under-voltage must hold for 3 us before the latch sets.
// - supply below the power-on threshold gives lockout with both switch commands off.
// - the supply-low condition must hold for 3 us before lockout asserts.
// - mux control high routes the main rail to the standby rail.
// - with mux control low the main rail stays selected while above regulator output minus 10 mV.
// - with mux control low the regulator output is taken once the main rail drops below that level.
// - after the regulator is taken the main rail returns only above regulator output plus 40 mV.
// - the linear regulator is enabled as soon as the supply is up, whatever the switching state.

module flrm_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // comparator and control pins
  input wire flrm_pkg::flrm_cmp_t cmp_pin,
  // pulse-width requests
  input wire flrm_pkg::flrm_gate_t pwm_req,
  // switch commands
  output flrm_pkg::flrm_gate_t gate_cmd,
  // fault status
  output flrm_pkg::flrm_fault_t fault,
  // standby rail source and regulator
  output logic standby_from_main,
  output logic standby_from_regulator,
  output logic regulator_enable
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [`FLRM_NUM_PINS-1:0] sync_a;
  logic [`FLRM_NUM_PINS-1:0] sync_b;
  flrm_pkg::flrm_cmp_t cmp_s;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= cmp_pin;
      sync_b <= sync_a;
    end
  end

  assign cmp_s = sync_b;

  // ----------------------------------------
  // fault filters
  // ----------------------------------------
  localparam logic [`FLRM_FILT_W-1:0] FILT_CYC [`FLRM_NUM_CH] = '{
    16'(`FLRM_OV_CYC),
    16'(`FLRM_UV_CYC),
    16'(`FLRM_UVLO_CYC)
  };

  wire [`FLRM_NUM_CH-1:0] filt_in = {cmp_s.supply_low, cmp_s.uv_low, cmp_s.ov_high};
  logic [`FLRM_NUM_CH-1:0] filt_hit;

  generate
    for (genvar ch = 0; ch < `FLRM_NUM_CH; ch++) begin : g_filt
      flrm_filter #(
        .CYCLES(FILT_CYC[ch])
      ) u_filt (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_level(filt_in[ch]),
        .hit(filt_hit[ch])
      );
    end
  endgenerate

  wire ov_hit = filt_hit[`FLRM_CH_OV];
  wire uv_hit = filt_hit[`FLRM_CH_UV];
  wire lock_hit = filt_hit[`FLRM_CH_UVLO];

  // ----------------------------------------
  // fault latches
  // ----------------------------------------
  logic ov_latch;
  logic uv_latch;
  wire next_ov_latch = ov_latch | ov_hit;
  wire next_uv_latch = uv_latch | uv_hit;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ov_latch <= 1'h0;
      uv_latch <= 1'h0;
    end else begin
      ov_latch <= next_ov_latch;
      uv_latch <= next_uv_latch;
    end
  end

  // ----------------------------------------
  // switch command override
  // ----------------------------------------
  flrm_pkg::flrm_gate_t next_gate;
  flrm_pkg::flrm_fault_t next_fault;
  wire gate_hs_ok = !lock_hit && !ov_latch && !uv_latch;
  wire gate_ls_ovp = !lock_hit && ov_latch;
  wire gate_ls_ok = !lock_hit && !ov_latch && !uv_latch;

  assign next_gate.hs = gate_hs_ok && pwm_req.hs;
  assign next_gate.ls = gate_ls_ovp || (gate_ls_ok && pwm_req.ls);
  assign next_fault.ov = ov_latch;
  assign next_fault.uv = uv_latch;
  assign next_fault.lockout = lock_hit;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gate_cmd <= `FLRM_GATE_RST;
      fault <= `FLRM_FAULT_RST;
    end else begin
      gate_cmd <= next_gate;
      fault <= next_fault;
    end
  end

  // ----------------------------------------
  // standby rail selector
  // ----------------------------------------
  flrm_pkg::flrm_sel_state_t sel_state;
  flrm_pkg::flrm_sel_state_t next_sel;

  always_comb begin
    next_sel = sel_state;
    if (cmp_s.mux_ctrl) begin
      next_sel = flrm_pkg::FLRM_SEL_MAIN;
    end else begin
      case (sel_state)
        flrm_pkg::FLRM_SEL_MAIN: begin
          if (cmp_s.main_low) begin
            next_sel = flrm_pkg::FLRM_SEL_REG;
          end else begin
            next_sel = flrm_pkg::FLRM_SEL_MAIN;
          end
        end
        flrm_pkg::FLRM_SEL_REG: begin
          if (cmp_s.main_high) begin
            next_sel = flrm_pkg::FLRM_SEL_MAIN;
          end else begin
            next_sel = flrm_pkg::FLRM_SEL_REG;
          end
        end
        default: begin
          next_sel = flrm_pkg::FLRM_SEL_MAIN;
        end
      endcase
    end
  end

  wire next_stby_main = (next_sel == flrm_pkg::FLRM_SEL_MAIN);
  wire next_reg_en = !cmp_s.supply_low;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sel_state <= flrm_pkg::FLRM_SEL_MAIN;
      standby_from_main <= `FLRM_STBY_MAIN_RST;
      standby_from_regulator <= `FLRM_STBY_REG_RST;
      regulator_enable <= `FLRM_REG_EN_RST;
    end else begin
      sel_state <= next_sel;
      standby_from_main <= next_stby_main;
      standby_from_regulator <= !next_stby_main;
      regulator_enable <= next_reg_en;
    end
  end

  // ----------------------------------------
  // checks: run-length helpers
  // ----------------------------------------
  localparam int OV_CYC_I = `FLRM_OV_CYC;
  localparam int UV_CYC_I = `FLRM_UV_CYC;
  localparam int UVLO_CYC_I = `FLRM_UVLO_CYC;
  logic [`FLRM_FILT_W-1:0] chk_run [`FLRM_NUM_CH];

  generate
    for (genvar ch = 0; ch < `FLRM_NUM_CH; ch++) begin : g_chk
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          chk_run[ch] <= 16'h0000;
        end else if (!filt_in[ch]) begin
          chk_run[ch] <= 16'h0000;
        end else if (chk_run[ch] != 16'hFFFF) begin
          chk_run[ch] <= chk_run[ch] + 16'h0001;
        end
      end
    end
  endgenerate

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // checks: faults
  // ----------------------------------------
  property p_ov_watch;
    (chk_run[0] == 16'(OV_CYC_I)) |-> ##2 fault.ov;
  endproperty
  a_ov_watch: assert property (p_ov_watch) else $error("over-voltage run not latched");

  property p_ov_gate;
    ov_latch && !lock_hit |=> gate_cmd.ls && !gate_cmd.hs;
  endproperty
  a_ov_gate: assert property (p_ov_gate) else $error("over-voltage switch state wrong");

  property p_ov_filter;
    $rose(ov_latch) |-> $past(32'(chk_run[0])) == OV_CYC_I;
  endproperty
  a_ov_filter: assert property (p_ov_filter) else $error("over-voltage latched too early");

  property p_uv_set;
    (chk_run[1] == 16'(UV_CYC_I)) |=> uv_latch ##1 fault.uv;
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("under-voltage not latched");

  property p_uv_off;
    uv_latch && !ov_latch |=> !gate_cmd.hs && !gate_cmd.ls;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("switch on under under-voltage");

  property p_uv_filter;
    $rose(uv_hit) |-> $past(32'(chk_run[1])) == UV_CYC_I - 1;
  endproperty
  a_uv_filter: assert property (p_uv_filter) else $error("under-voltage filter length wrong");

  property p_lock_off;
    lock_hit |=> !gate_cmd.hs && !gate_cmd.ls && fault.lockout;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("switch on during lockout");

  property p_lock_filter;
    $rose(lock_hit) |-> $past(32'(chk_run[2])) == UVLO_CYC_I - 1;
  endproperty
  a_lock_filter: assert property (p_lock_filter) else $error("lockout filter length wrong");

  property p_latch_hold;
    fault.ov || fault.uv |=> !$fell(fault.ov) && !$fell(fault.uv);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("fault latch released");

  // ----------------------------------------
  // checks: selector and regulator
  // ----------------------------------------
  property p_mux_main;
    cmp_s.mux_ctrl |=> standby_from_main && !standby_from_regulator;
  endproperty
  a_mux_main: assert property (p_mux_main) else $error("mux high did not pick main rail");

  property p_keep_main;
    !cmp_s.mux_ctrl && standby_from_main && !cmp_s.main_low |=> standby_from_main;
  endproperty
  a_keep_main: assert property (p_keep_main) else $error("main rail dropped without cause");

  property p_to_reg;
    !cmp_s.mux_ctrl && cmp_s.main_low |=> standby_from_regulator && !standby_from_main;
  endproperty
  a_to_reg: assert property (p_to_reg) else $error("regulator not taken on low main");

  property p_hyst;
    !cmp_s.mux_ctrl && standby_from_regulator && !cmp_s.main_high |=> standby_from_regulator;
  endproperty
  a_hyst: assert property (p_hyst) else $error("main rail returned below upper level");

  property p_reg_en;
    !cmp_s.supply_low |=> regulator_enable;
  endproperty
  a_reg_en: assert property (p_reg_en) else $error("regulator not enabled with supply up");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_ov: cover property ($rose(fault.ov));
  c_uv: cover property ($rose(fault.uv));
  c_lock: cover property ($rose(fault.lockout) ##[1:20] $fell(fault.lockout));
  c_sel_reg: cover property ($rose(standby_from_regulator) ##[1:50] $rose(standby_from_main));

endmodule // flrm_top

// file: test/flrm_fet_model.sv
`timescale 1ns/1ns

// ----------------------------------------
// power switch pair on the far side
// ----------------------------------------
module flrm_fet_model (
  // clock
  input wire logic mclk,
  // gate drive
  input wire flrm_pkg::flrm_gate_t gate,
  // switch node and overlap count
  output logic sw_node,
  output int shoot_count
);
  logic node = 1'h0;
  int shoots = 0;

  assign sw_node = node;
  assign shoot_count = shoots;

  // both switches on shorts the supply: count it
  always @(posedge mclk) begin
    if (gate.hs && gate.ls) begin
      shoots <= shoots + 1;
    end
    if (gate.hs && !gate.ls) begin
      node <= 1'h1;
    end else if (gate.ls && !gate.hs) begin
      node <= 1'h0;
    end else begin
      // node floats with no pull, so it never keeps a stale level
      node <= ~node;
    end
  end
endmodule // flrm_fet_model

// file: test/fault_latch_and_rail_mux_bench.sv
`timescale 1ns/1ns

module fault_latch_and_rail_mux_bench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int OV = 5;
  localparam int UV = 4;
  localparam int SUP = 3;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  flrm_pkg::flrm_cmp_t cmp_pin = 6'h00;
  flrm_pkg::flrm_gate_t pwm_req = 2'h0;
  flrm_pkg::flrm_gate_t gate_cmd;
  flrm_pkg::flrm_fault_t fault;
  logic standby_from_main;
  logic standby_from_regulator;
  logic regulator_enable;
  logic sw_node;
  int shoot_count;
  int fail_count = 0;
  int num_checks = 0;
  logic [2:0] seen_fault;
  logic last_node;

  always #5 mclk = ~mclk;

  flrm_top flrm_top_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .cmp_pin(cmp_pin),
    .pwm_req(pwm_req),
    .gate_cmd(gate_cmd),
    .fault(fault),
    .standby_from_main(standby_from_main),
    .standby_from_regulator(standby_from_regulator),
    .regulator_enable(regulator_enable)
  );

  flrm_fet_model flrm_fet_model_i (
    .mclk(mclk),
    .gate(gate_cmd),
    .sw_node(sw_node),
    .shoot_count(shoot_count)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic test_done();
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hold one pin high for n cycles, collecting any fault seen then and in the 8 cycles after
  task automatic pulse(input int idx, input int n);
    seen_fault = 3'h0;
    cmp_pin[idx] = 1'h1;
    for (int i = 0; i < n + 8; i++) begin
      if (i == n) begin
        cmp_pin[idx] = 1'h0;
      end
      @(negedge mclk);
      seen_fault = seen_fault | fault;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rst_n = 1'h0;
    cycles(6);
    check("rst_gate", gate_cmd, 8'h00);
    check("rst_fault", fault, 8'h00);
    check("rst_sel", {standby_from_regulator, standby_from_main}, 8'h01);
    check("rst_reg_en", regulator_enable, 8'h00);
    rst_n = 1'h1;
    cycles(4);
  endtask

  task automatic t_pass();
    check("reg_en_up", regulator_enable, 8'h01);
    pwm_req = 2'h2;
    cycles(2);
    check("pass_hs", gate_cmd, 8'h02);
    pwm_req = 2'h1;
    cycles(2);
    check("pass_ls", gate_cmd, 8'h01);
  endtask

  task automatic t_mux();
    cmp_pin.mux_ctrl = 1'h1;
    cmp_pin.main_low = 1'h1;
    cycles(6);
    check("mux_forced", {standby_from_regulator, standby_from_main}, 8'h01);
    cmp_pin.mux_ctrl = 1'h0;
    cycles(6);
    check("mux_to_reg", {standby_from_regulator, standby_from_main}, 8'h02);
    cmp_pin.main_low = 1'h0;
    cycles(6);
    check("mux_hyst", {standby_from_regulator, standby_from_main}, 8'h02);
    cmp_pin.main_high = 1'h1;
    cycles(6);
    check("mux_back", {standby_from_regulator, standby_from_main}, 8'h01);
    cmp_pin.main_high = 1'h0;
    cycles(6);
    check("mux_keep", {standby_from_regulator, standby_from_main}, 8'h01);
  endtask

  task automatic t_lockout();
    pwm_req = 2'h2;
    pulse(SUP, 299);
    check("lock_short", seen_fault[0], 8'h00);
    cmp_pin.supply_low = 1'h1;
    cycles(310);
    check("lock_fault", fault, 8'h01);
    check("lock_gate", gate_cmd, 8'h00);
    check("lock_reg_en", regulator_enable, 8'h00);
    cmp_pin.supply_low = 1'h0;
    cycles(6);
    check("lock_free", fault, 8'h00);
    check("lock_gate_back", gate_cmd, 8'h02);
    check("reg_en_back", regulator_enable, 8'h01);
  endtask

  task automatic t_under();
    pwm_req = 2'h1;
    pulse(UV, 299);
    check("uv_short", seen_fault[1], 8'h00);
    pulse(UV, 300);
    check("uv_latch", fault, 8'h02);
    check("uv_gate", gate_cmd, 8'h00);
    last_node = sw_node;
    cycles(1);
    check("uv_node_float", sw_node, {7'h00, ~last_node});
  endtask

  task automatic t_over();
    pwm_req = 2'h2;
    pulse(OV, 99);
    check("ov_short", seen_fault[2], 8'h00);
    pulse(OV, 100);
    check("ov_latch", fault, 8'h04);
    check("ov_gate", gate_cmd, 8'h01);
    check("ov_node", sw_node, 8'h00);
    pulse(UV, 300);
    check("ov_uv_sticky", fault, 8'h06);
    check("ov_over_uv", gate_cmd, 8'h01);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    t_reset();
    t_pass();
    t_mux();
    t_lockout();
    t_under();
    t_reset();
    t_over();
    check("no_overlap", 8'(shoot_count), 8'h00);
    test_done();
  end

  initial begin
    #200000;
    fail_count++;
    test_done();
  end
endmodule // fault_latch_and_rail_mux_bench
